//--- dv/bus_master_model.sv
// two-wire bus master driving the block's clock and data pins
// assumes a pull-up: data is low while any party pulls it
`default_nettype none
module bus_master_model (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // clock idles high; data moves while it is low
  task automatic bit_io(input logic b, output logic r);
    sda_pull_o = !b;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    r = sda_i;
    tick(4);
    scl_o = 1'b0;
    tick(4);
  endtask
  task automatic start_cond();
    sda_pull_o = 1'b0;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_pull_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
    tick(4);
  endtask
  task automatic stop_cond();
    sda_pull_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_pull_o = 1'b0;
    tick(8);
  endtask
  // eight bits, then ninth; ack_o when receiver pulled data
  task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                         output logic ack_o);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(last, r);
    ack_o = !r;
  endtask
endmodule // bus_master_model
`default_nettype wire

//--- dv/monitor_acq_checker.sv
// concurrent checks on the block's ports
// assumes one clock domain; bound to the block's top below
`default_nettype none
module monitor_acq_checker #(
  parameter CONV_CYCLES = 20,
  parameter CNT_W = 18
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic supply_low_detect_i,
  input wire logic sda_oe_o,
  input wire logic conv_start_o,
  input wire logic [2:0] conv_select_o,
  input wire logic conv_diff_o,
  input wire logic conv_bias_high_o,
  input wire logic bias_first_o,
  input wire logic bias_third_o,
  input wire logic term_second_o,
  input wire logic term_fourth_o,
  input wire logic busy_o,
  input wire logic [7:0] control_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic [CNT_W-1:0] gap_q;
  logic [2:0] prev_q;
  logic start_d_q;
  logic have_q;
  // ------------------------------------------
  // conversion gap, last step
  // ------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_q <= CNT_W'(CONV_CYCLES);
      prev_q <= 3'h0;
      start_d_q <= 1'b0;
      have_q <= 1'b0;
    end else begin
      start_d_q <= conv_start_o;
      if (conv_start_o) gap_q <= '0;
      else if (supply_low_detect_i) gap_q <= CNT_W'(CONV_CYCLES);
      else if (gap_q < CNT_W'(CONV_CYCLES)) gap_q <= gap_q + 1'b1;
      if (!busy_o) begin
        have_q <= 1'b0;
      end else if (start_d_q) begin
        have_q <= 1'b1;
        prev_q <= conv_select_o;
      end
    end
  end
  // ------------------------------------------
  // properties
  // ------------------------------------------
  sequence s_low_held;
    supply_low_detect_i [*5];
  endsequence
  sequence s_remote;
    bias_first_o || bias_third_o || term_second_o || term_fourth_o;
  endsequence
  a_ctrl_reset: assert property ($rose(rst_b_i) |-> control_o == 8'h00 && !busy_o)
    else $error("control or busy set after reset");
  a_supply_clears: assert property (s_low_held |-> control_o == 8'h00)
    else $error("control kept during supply low");
  a_supply_quiet: assert property (s_low_held |-> !busy_o && !conv_start_o && !sda_oe_o)
    else $error("activity during supply low");
  a_conv_spacing: assert property (conv_start_o |-> gap_q >= CONV_CYCLES - 1)
    else $error("conversion cut short");
  a_busy_in_conv: assert property (conv_start_o && !supply_low_detect_i |=> busy_o [*2])
    else $error("busy low during conversion");
  a_fixed_order: assert property (start_d_q && have_q |-> conv_select_o >= prev_q || prev_q == 3'h5)
    else $error("acquisition order broken");
  a_bias_pairs: assert property (s_remote |-> bias_first_o == term_second_o &&
    bias_third_o == term_fourth_o && !(bias_first_o && bias_third_o))
    else $error("bias and termination mismatch");
  a_remote_diff: assert property (s_remote |-> conv_diff_o)
    else $error("remote sample not differential");
  a_bias_high: assert property (conv_bias_high_o |-> bias_first_o || bias_third_o)
    else $error("high bias outside remote step");
endmodule // monitor_acq_checker
bind monitor_acquisition_control monitor_acq_checker #(
  .CONV_CYCLES(CONV_CYCLES), .CNT_W(CNT_W)) monitor_acq_checker_i (
  .*);
`default_nettype wire

//--- dv/tb_monitor_acquisition_control.sv
// self-checking bench for the monitor acquisition control block
// assumes block, master model and checker compiled alongside
`default_nettype none
`include "monitor_defs.vh"
module tb_monitor_acquisition_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 20;
  localparam int LIMIT = 40000;
  logic clock_i, rst_b_i, scl, sda_pull, sda_wire, sda_o, sda_oe, adr_lo, adr_hi;
  logic supply_low, conv_start, conv_diff, bias_high, bias_first, bias_third;
  logic term_second, term_fourth, busy;
  logic [14:0] conv_data;
  logic [2:0] conv_select;
  logic [7:0] control;
  logic [6:0] dev;
  logic [1:0] start_d;
  logic [8:0] log_q[$];
  int bad_count, checked, cycles;
  monitor_acquisition_control #(.CONV_CYCLES(CONV)) monitor_acquisition_control_i (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .address_select_low_i(adr_lo), .address_select_high_i(adr_hi),
    .supply_low_detect_i(supply_low), .conv_data_i(conv_data), .conv_start_o(conv_start),
    .conv_select_o(conv_select), .conv_diff_o(conv_diff), .conv_bias_high_o(bias_high),
    .bias_first_o(bias_first), .bias_third_o(bias_third), .term_second_o(term_second),
    .term_fourth_o(term_fourth), .busy_o(busy), .control_o(control));
  bus_master_model bus_master_model_i (.clock_i(clock_i), .sda_i(sda_wire), .scl_o(scl),
    .sda_pull_o(sda_pull));
  assign sda_wire = !(sda_pull || (sda_oe && !sda_o));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = !clock_i;
  end
  // ------------------------------------------
  // converter model, step log, time limit
  // ------------------------------------------
  function automatic logic [14:0] conv_val(input logic [2:0] sel, input logic hi);
    return 15'h1200 + 15'(sel) * 15'h0111 + (hi ? 15'h0340 : 15'h0000);
  endfunction
  always @(negedge clock_i) begin
    conv_data <= conv_val(conv_select, bias_high);
    start_d <= {start_d[0], conv_start};
    if (start_d[1]) log_q.push_back({conv_select, conv_diff, bias_high, bias_first,
      bias_third, term_second, term_fourth});
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ------------------------------------------
  // access tasks
  // ------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic a1, a2, a3;
    bus_master_model_i.start_cond();
    bus_master_model_i.byte_io({dev, 1'b0}, 1'b1, rx, a1);
    bus_master_model_i.byte_io(a, 1'b1, rx, a2);
    bus_master_model_i.byte_io(d, 1'b1, rx, a3);
    bus_master_model_i.stop_cond();
    ok = a1 & a2 & a3;
  endtask
  task automatic rd_reg(input logic [7:0] a, input int n, output logic [15:0] v,
                        output logic ok);
    logic [7:0] rx;
    logic a1, a2, a3, nk;
    v = 16'h0000;
    bus_master_model_i.start_cond();
    bus_master_model_i.byte_io({dev, 1'b0}, 1'b1, rx, a1);
    bus_master_model_i.byte_io(a, 1'b1, rx, a2);
    bus_master_model_i.start_cond();
    bus_master_model_i.byte_io({dev, 1'b1}, 1'b1, rx, a3);
    for (int i = 1; i <= n; i++) begin
      bus_master_model_i.byte_io(8'hFF, i == n, rx, nk);
      v = {v[7:0], rx};
    end
    bus_master_model_i.stop_cond();
    ok = a1 & a2 & a3;
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clock_i);
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial begin
    logic [15:0] v;
    logic ok;
    logic [8:0] exp_log [5];
    logic [7:0] ra [5];
    logic [15:0] ev [5];
    rst_b_i = 1'b0;
    {adr_hi, adr_lo, supply_low} = 3'h0;
    {bad_count, checked, cycles} = '0;
    dev = {`SLAVE_BASE, 2'b00};
    repeat (5) @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (6) @(negedge clock_i);
    check(16'(control), 16'h0000);
    wr_reg(`REG_TRIGGER, 8'h00, ok);
    wait_idle();
    check({15'(log_q.size()), ok}, 16'h0003);
    rd_reg(8'h04, 2, v, ok);
    check(v, {1'b1, (conv_val(3'h0, 1'b0) - `CELSIUS_OFFSET) & `TEMP_MASK});
    rd_reg(8'h04, 1, v, ok);
    check(v, 16'h0000);
    wr_reg(`REG_CONTROL, 8'hB6, ok);
    rd_reg(`REG_CONTROL, 1, v, ok);
    check(v, 16'h00B6);
    log_q.delete();
    wr_reg(`REG_TRIGGER, 8'h5A, ok);
    wait_idle();
    exp_log = '{9'h000, 9'h06A, 9'h07A, 9'h0E0, 9'h140};
    check(16'(log_q.size()), 16'h0005);
    foreach (exp_log[i]) check(16'(log_q[i]), 16'(exp_log[i]));
    rd_reg(8'h00, 1, v, ok);
    check(v, 16'h002B);
    ra = '{8'h04, 8'h06, 8'h08, 8'h0A, 8'h0E};
    ev = '{{1'b1, conv_val(3'h0, 1'b0) & `TEMP_MASK},
      {1'b1, (conv_val(3'h1, 1'b1) - conv_val(3'h1, 1'b0)) & `TEMP_MASK},
      16'h0000, {1'b1, conv_val(3'h3, 1'b0)}, {1'b1, conv_val(3'h5, 1'b0)}};
    foreach (ra[i]) begin
      rd_reg(ra[i], 2, v, ok);
      check(v, ev[i]);
    end
    rd_reg(8'h00, 1, v, ok);
    check(v, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      {adr_hi, adr_lo} = 2'(k);
      repeat (4) @(negedge clock_i);
      dev = {`SLAVE_BASE, 2'(k)};
      rd_reg(`REG_CONTROL, 1, v, ok);
      check({7'h00, ok, v[7:0]}, 16'h01B6);
      dev = {`SLAVE_BASE, 2'(k + 1)};
      wr_reg(`REG_CONTROL, 8'h00, ok);
      check({15'(control), ok}, 16'h016C);
    end
    dev = {`SLAVE_BASE, 2'b11};
    wr_reg(`REG_CONTROL, 8'h40, ok);
    log_q.delete();
    wr_reg(`REG_TRIGGER, 8'h01, ok);
    for (int n = 0; n < 500 && log_q.size() < 3; n++) @(negedge clock_i);
    check({14'(log_q.size() >= 3), busy, ok}, 16'h0007);
    supply_low = 1'b1;
    repeat (6) @(negedge clock_i);
    check({busy, control}, 16'h0000);
    log_q.delete();
    wr_reg(`REG_TRIGGER, 8'h01, ok);
    check({15'(log_q.size()), ok}, 16'h0000);
    supply_low = 1'b0;
    repeat (6) @(negedge clock_i);
    rd_reg(8'h0E, 2, v, ok);
    check({15'h0000, ok}, 16'h0001);
    check(v, 16'h0000);
    tally_and_finish();
  end
endmodule // tb_monitor_acquisition_control
`default_nettype wire

//--- hdl/monitor_acquisition_control.v
// acquisition sequencer, register file and two-wire slave of the monitor
// assumes converter and supply detector outputs; bus pins are raw levels
//
// How it works
// (R1) steps run die temp, first, second, third, fourth input, then supply
// (R2) control mode bits pick multiplexer inputs and measurement kinds
// (R3) voltage/current go straight to data; temperature is processed first
// (R4) current and temperature on a pair use differential sampling
// (R5) two address pins pick one of four slave addresses
// (R6) bus traffic ignored while supply is low
// (R7) supply low holds control and data registers at zero
// (R8) power-on reset clears control and every data register
// (R9) bus runs up to 400 kbit/s; bench master runs faster, one bit per 16 clocks (160 ns)
// (R10) write to trigger register starts a single or repeated run
// (R11) each data register flags fresh data; a read clears it
// (R12) remote diode uses two conversions at different bias currents
// (R13) bias source on first or third input during remote temperature
// (R14) termination on second or fourth input during remote temperature
// (R15) each conversion takes 1.5 ms before its result is taken
// (R16) temperature is 13 bits, sixteenth-degree steps
// (R17) temperature may be coded in Kelvin instead of Celsius
// (R18) upper byte bit 7 is the fresh flag; status bit follows it, and is also cleared when a command byte points at that upper byte
// (R19) control bit 7 sets the format of all temperature results
// (R20) reset control measures die temperature only, inputs idle
// (R21) byte and word read and write commands are served
// (R22) repeated mode restarts after the supply step without new trigger
`default_nettype none
`include "monitor_defs.vh"
module monitor_acquisition_control #(
  parameter CONV_CYCLES = `CONV_TIME_NS / `CLK_PERIOD_NS,
  parameter CNT_W = 18
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  input wire address_select_low_i,
  input wire address_select_high_i,
  input wire supply_low_detect_i,
  input wire [14:0] conv_data_i,
  output reg conv_start_o,
  output reg [2:0] conv_select_o,
  output reg conv_diff_o,
  output reg conv_bias_high_o,
  output reg bias_first_o,
  output reg bias_third_o,
  output reg term_second_o,
  output reg term_fourth_o,
  output wire busy_o,
  output wire [7:0] control_o
);
  localparam SQ_IDLE = 2'h0;
  localparam SQ_CHECK = 2'h1;
  localparam SQ_WAIT = 2'h2;
  localparam [CNT_W-1:0] CONV_LAST = CONV_CYCLES[CNT_W-1:0] - 1'b1;
  // ------------------------------------------------------------
  // synchronisers for outside levels
  // ------------------------------------------------------------
  reg uv_m_q, uv_q, al_m_q, al_q, ah_m_q, ah_q;
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      uv_m_q <= 1'b1;
      uv_q <= 1'b1;
      al_m_q <= 1'b0;
      al_q <= 1'b0;
      ah_m_q <= 1'b0;
      ah_q <= 1'b0;
    end else begin
      uv_m_q <= supply_low_detect_i;
      uv_q <= uv_m_q;
      al_m_q <= address_select_low_i;
      al_q <= al_m_q;
      ah_m_q <= address_select_high_i;
      ah_q <= ah_m_q;
    end
  end
  // ------------------------------------------------------------
  // decode functions
  // ------------------------------------------------------------
  function step_on;
    input [2:0] step;
    input [7:0] ctrl;
    begin
      case (step)
        `STEP_DIE: step_on = 1'b1;
        `STEP_FIRST: step_on = ctrl[`CTRL_PAIR_A_HI:`CTRL_PAIR_A_LO] != `PAIR_OFF;
        `STEP_SECOND: step_on = ctrl[`CTRL_PAIR_A_HI:`CTRL_PAIR_A_LO] == `PAIR_SINGLE;
        `STEP_THIRD: step_on = ctrl[`CTRL_PAIR_B_HI:`CTRL_PAIR_B_LO] != `PAIR_OFF;
        `STEP_FOURTH: step_on = ctrl[`CTRL_PAIR_B_HI:`CTRL_PAIR_B_LO] == `PAIR_SINGLE;
        `STEP_VCC: step_on = ctrl[`CTRL_VCC_EN];
        default: step_on = 1'b0;
      endcase
    end
  endfunction
  function [1:0] pair_mode;
    input [2:0] step;
    input [7:0] ctrl;
    begin
      if (step == `STEP_FIRST) begin
        pair_mode = ctrl[`CTRL_PAIR_A_HI:`CTRL_PAIR_A_LO];
      end else if (step == `STEP_THIRD) begin
        pair_mode = ctrl[`CTRL_PAIR_B_HI:`CTRL_PAIR_B_LO];
      end else begin
        pair_mode = `PAIR_OFF;
      end
    end
  endfunction
  function [2:0] slot_of;
    input [3:0] ptr;
    reg [3:0] rel;
    begin
      rel = ptr - `REG_DATA_BASE;
      slot_of = rel[3:1];
    end
  endfunction
  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  wire wr_ev, cmd_ev, rd_ev;
  wire [7:0] wr_data;
  reg [7:0] rd_data;
  wire [6:0] slave_addr = {`SLAVE_BASE, ah_q, al_q}; // R5
  two_wire_slave u_slave (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .enable_i(~uv_q), // R6
    .scl_i(scl_i),
    .sda_i(sda_i),
    .address_i(slave_addr),
    .rd_data_i(rd_data),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .wr_o(wr_ev),
    .cmd_o(cmd_ev),
    .wr_data_o(wr_data),
    .rd_o(rd_ev)
  );
  // ------------------------------------------------------------
  // registers and sequencer state
  // ------------------------------------------------------------
  reg [7:0] ctrl_q;
  reg [3:0] ptr_q;
  reg [14:0] data_q [0:`NUM_SLOTS-1];
  reg [`NUM_SLOTS-1:0] fresh_q, stat_q;
  reg trig_q;
  reg [1:0] sq_q;
  reg [2:0] step_q;
  reg phase_q;
  reg [CNT_W-1:0] cnt_q;
  reg [14:0] samp0_q;
  assign control_o = ctrl_q;
  assign busy_o = sq_q != SQ_IDLE;
  wire is_data = ptr_q >= `REG_DATA_BASE;
  wire [2:0] rd_slot = slot_of(ptr_q);
  wire [1:0] cur_mode = pair_mode(step_q, ctrl_q);
  wire remote_t = cur_mode == `PAIR_TEMP;
  wire is_temp = (step_q == `STEP_DIE) | remote_t;
  wire conv_end = (sq_q == SQ_WAIT) && (cnt_q == CONV_LAST); // R15
  wire [14:0] kelvin = remote_t ? ((conv_data_i - samp0_q) & `TEMP_MASK)
                                : (conv_data_i & `TEMP_MASK); // R12 R16
  wire [14:0] t_out = ctrl_q[`CTRL_KELVIN] ? kelvin
                      : ((kelvin - `CELSIUS_OFFSET) & `TEMP_MASK); // R17 R19
  wire [14:0] result = is_temp ? t_out : conv_data_i; // R3
  wire store = conv_end && !(remote_t && !phase_q);
  // ------------------------------------------------------------
  // read data mux
  // ------------------------------------------------------------
  always @* begin
    rd_data = 8'h00;
    if (ptr_q == `REG_STATUS) begin
      rd_data = {1'b0, busy_o, stat_q};
    end else if (ptr_q == `REG_CONTROL) begin
      rd_data = ctrl_q;
    end else if (is_data && !ptr_q[0]) begin
      rd_data = {fresh_q[rd_slot], data_q[rd_slot][14:8]}; // R18
    end else if (is_data) begin
      rd_data = data_q[rd_slot][7:0];
    end
  end
  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  integer i;
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= `CTRL_RESET; // R8 R20
      ptr_q <= `REG_STATUS;
      trig_q <= 1'b0;
      fresh_q <= {`NUM_SLOTS{1'b0}};
      stat_q <= {`NUM_SLOTS{1'b0}};
      for (i = 0; i < `NUM_SLOTS; i = i + 1) begin
        data_q[i] <= `DATA_RESET; // R8
      end
    end else if (uv_q) begin
      ctrl_q <= `CTRL_RESET; // R7
      ptr_q <= `REG_STATUS;
      trig_q <= 1'b0;
      fresh_q <= {`NUM_SLOTS{1'b0}};
      stat_q <= {`NUM_SLOTS{1'b0}};
      for (i = 0; i < `NUM_SLOTS; i = i + 1) begin
        data_q[i] <= `DATA_RESET; // R7
      end
    end else begin
      trig_q <= 1'b0;
      // R21
      if (wr_ev && cmd_ev) begin
        ptr_q <= wr_data[3:0];
        if (wr_data[3:0] >= `REG_DATA_BASE && !wr_data[0]) begin
          stat_q[slot_of(wr_data[3:0])] <= 1'b0; // R18
        end
      end else if (wr_ev) begin
        ptr_q <= ptr_q + 4'h1;
        if (ptr_q == `REG_CONTROL) begin
          ctrl_q <= wr_data; // R2
        end
        if (ptr_q == `REG_TRIGGER) begin
          trig_q <= 1'b1; // R10
        end
      end else if (rd_ev) begin
        ptr_q <= ptr_q + 4'h1;
        if (is_data && !ptr_q[0]) begin
          fresh_q[rd_slot] <= 1'b0; // R11
          stat_q[rd_slot] <= 1'b0; // R18
        end
      end
      // new result wins over a clear in the same cycle
      if (store) begin
        data_q[step_q] <= result; // R3
        fresh_q[step_q] <= 1'b1; // R11
        stat_q[step_q] <= 1'b1; // R18
      end
    end
  end
  // ------------------------------------------------------------
  // acquisition sequencer
  // ------------------------------------------------------------
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sq_q <= SQ_IDLE;
      step_q <= `STEP_DIE;
      phase_q <= 1'b0;
      cnt_q <= {CNT_W{1'b0}};
      samp0_q <= `DATA_RESET;
      conv_start_o <= 1'b0;
    end else if (uv_q) begin
      sq_q <= SQ_IDLE;
      step_q <= `STEP_DIE;
      phase_q <= 1'b0;
      cnt_q <= {CNT_W{1'b0}};
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      case (sq_q)
        SQ_IDLE: begin
          if (trig_q) begin
            step_q <= `STEP_DIE; // R10
            sq_q <= SQ_CHECK;
          end
        end
        SQ_CHECK: begin
          if (step_on(step_q, ctrl_q)) begin
            conv_start_o <= 1'b1; // R2
            phase_q <= 1'b0;
            cnt_q <= {CNT_W{1'b0}};
            sq_q <= SQ_WAIT;
          end else if (step_q == `STEP_VCC) begin
            step_q <= `STEP_DIE;
            sq_q <= ctrl_q[`CTRL_REPEAT] ? SQ_CHECK : SQ_IDLE; // R22
          end else begin
            step_q <= step_q + 3'h1; // R1
          end
        end
        SQ_WAIT: begin
          cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
          if (conv_end && remote_t && !phase_q) begin
            samp0_q <= conv_data_i; // R12
            phase_q <= 1'b1;
            cnt_q <= {CNT_W{1'b0}};
            conv_start_o <= 1'b1;
          end else if (conv_end) begin
            phase_q <= 1'b0;
            if (step_q == `STEP_VCC) begin
              step_q <= `STEP_DIE;
              sq_q <= ctrl_q[`CTRL_REPEAT] ? SQ_CHECK : SQ_IDLE; // R22
            end else begin
              step_q <= step_q + 3'h1; // R1
              sq_q <= SQ_CHECK;
            end
          end
        end
        default: begin
          sq_q <= SQ_IDLE;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // multiplexer, bias and termination drive
  // ------------------------------------------------------------
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_select_o <= `STEP_DIE;
      conv_diff_o <= 1'b0;
      conv_bias_high_o <= 1'b0;
      bias_first_o <= 1'b0;
      bias_third_o <= 1'b0;
      term_second_o <= 1'b0;
      term_fourth_o <= 1'b0;
    end else begin
      conv_select_o <= step_q; // R2
      conv_diff_o <= (sq_q == SQ_WAIT) && cur_mode[1]; // R4
      conv_bias_high_o <= (sq_q == SQ_WAIT) && remote_t && phase_q; // R12
      bias_first_o <= (sq_q == SQ_WAIT) && remote_t && step_q == `STEP_FIRST; // R13
      bias_third_o <= (sq_q == SQ_WAIT) && remote_t && step_q == `STEP_THIRD; // R13
      term_second_o <= (sq_q == SQ_WAIT) && remote_t && step_q == `STEP_FIRST; // R14
      term_fourth_o <= (sq_q == SQ_WAIT) && remote_t && step_q == `STEP_THIRD; // R14
    end
  end
endmodule // monitor_acquisition_control
`default_nettype wire

//--- hdl/monitor_defs.vh
// constants for the monitor acquisition control block
// assumes a 100 MHz system clock and plain Verilog-2005 tools
`ifndef MONITOR_DEFS_VH
`define MONITOR_DEFS_VH
// ------------------------------------------------------------
// register offsets (command byte values)
// ------------------------------------------------------------
`define REG_STATUS 4'h0
`define REG_CONTROL 4'h1
`define REG_TRIGGER 4'h2
`define REG_DATA_BASE 4'h4
`define REG_DATA_LAST 4'hF
// ------------------------------------------------------------
// control register fields and reset value
// ------------------------------------------------------------
`define CTRL_RESET 8'h00
`define CTRL_KELVIN 7
`define CTRL_REPEAT 6
`define CTRL_VCC_EN 5
`define CTRL_PAIR_B_HI 4
`define CTRL_PAIR_B_LO 3
`define CTRL_PAIR_A_HI 2
`define CTRL_PAIR_A_LO 1
// pair modes
`define PAIR_OFF 2'h0
`define PAIR_SINGLE 2'h1
`define PAIR_DIFF 2'h2
`define PAIR_TEMP 2'h3
// ------------------------------------------------------------
// acquisition steps, in fixed order
// ------------------------------------------------------------
`define STEP_DIE 3'h0
`define STEP_FIRST 3'h1
`define STEP_SECOND 3'h2
`define STEP_THIRD 3'h3
`define STEP_FOURTH 3'h4
`define STEP_VCC 3'h5
`define NUM_SLOTS 6
// ------------------------------------------------------------
// data format and timing
// ------------------------------------------------------------
`define DATA_RESET 15'h0000
`define TEMP_MASK 15'h1FFF
`define CELSIUS_OFFSET 15'h1112
`define STATUS_BUSY 6
`define CONV_TIME_NS 1500000
`define CLK_PERIOD_NS 10
// slave address upper bits; arbitrary value
`define SLAVE_BASE 5'h0B
`endif

//--- hdl/two_wire_slave.v
// byte-level two-wire bus slave: address match, command and data bytes
// assumes raw scl/sda pin levels; syncs them to clock_i itself
`default_nettype none
module two_wire_slave (
  input wire clock_i,
  input wire rst_b_i,
  input wire enable_i,
  input wire scl_i,
  input wire sda_i,
  input wire [6:0] address_i,
  input wire [7:0] rd_data_i,
  output wire sda_o,
  output reg sda_oe_o,
  output reg wr_o,
  output reg cmd_o,
  output reg [7:0] wr_data_o,
  output reg rd_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK_A = 3'h2;
  localparam ST_WRITE = 3'h3;
  localparam ST_ACK_W = 3'h4;
  localparam ST_READ = 3'h5;
  localparam ST_MACK = 3'h6;
  localparam ST_RNEXT = 3'h7;
  // ------------------------------------------------------------
  // pin synchronisers and edge detect
  // ------------------------------------------------------------
  reg scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  reg [2:0] st_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg rw_q, first_q;
  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire load = scl_fall & (((st_q == ST_ACK_A) & rw_q) | (st_q == ST_RNEXT));
  assign sda_o = 1'b0;
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i; // R9
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end
  // ------------------------------------------------------------
  // protocol engine
  // ------------------------------------------------------------
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_o <= 1'b0;
      cmd_o <= 1'b0;
      wr_data_o <= 8'h00;
      rd_o <= 1'b0;
    end else begin
      wr_o <= 1'b0;
      rd_o <= load;
      if (!enable_i || stop) begin
        st_q <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (load) begin
        st_q <= ST_READ;
        sh_q <= rd_data_i;
        cnt_q <= 4'h0;
        sda_oe_o <= ~rd_data_i[7];
      end else begin
        case (st_q)
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              if (st_q == ST_WRITE) begin
                wr_o <= 1'b1;
                cmd_o <= first_q;
                wr_data_o <= sh_q;
                first_q <= 1'b0;
                sda_oe_o <= 1'b1;
                st_q <= ST_ACK_W;
              end else if (sh_q[7:1] == address_i) begin
                rw_q <= sh_q[0];
                first_q <= ~sh_q[0];
                sda_oe_o <= 1'b1;
                st_q <= ST_ACK_A;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_ACK_A, ST_ACK_W: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              cnt_q <= 4'h0;
              st_q <= ST_WRITE;
            end
          end
          ST_READ: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                sda_oe_o <= 1'b0;
                st_q <= ST_MACK;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                sda_oe_o <= ~sh_q[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              st_q <= sda_s_q ? ST_IDLE : ST_RNEXT;
            end
          end
          ST_RNEXT: begin
            st_q <= ST_RNEXT;
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // two_wire_slave
`default_nettype wire
